// [verilog/fskrx_top.sv]
`timescale 1ns/100ps
`include "fskrx_params.svh"

// Overview of operation
// - Sample input every 300 kHz tick, correlate
// - Bit decisions at about 585.92 Hz
// - Each decision appends detected mark or space
// - Flag packet when 33 bits collected
// - Programmable detection threshold, default 0.1
// - Eleven bits per word, three words
// - Three second timeout ends reception
// - Timeout starts at receive, restarts per packet
// - Start enables ticks and timeout counter
// - Stop ticks, clear timeout when done
// - Sum bits of three 11-bit words
// - Clear bit buffer after packetizing
// - Word +1 is one code, -1 zero
// - Packet sum +3 one, -3 zero
// - Blue one, red zero, both otherwise
// - Indicate result before reception restarts
// - Correlate against 131.25 and 143.75 kHz
module fskrx_top
  import fskrx_pkg::*;
#(
  parameter int BIT_TICK_CYCLES = int'((`FSKRX_CLK_HZ * 64'd1000 + `FSKRX_BIT_DECISION_MHZ / 2) / `FSKRX_BIT_DECISION_MHZ),
  parameter int TIMEOUT_CYCLES = `FSKRX_TIMEOUT_S * `FSKRX_CLK_HZ,
  parameter int BLINK_CYCLES = int'((`FSKRX_BLINK_MS * 64'd25000000) / 1000)
)
(
  // Clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Converter samples, offset binary
  input wire logic [11:0] ADC_DATA,
  output logic SAMPLE_TICK,
  // Indicators
  output logic LED_BLUE,
  output logic LED_RED,
  output logic PACKET_FLAG
);

  localparam int SAMPLE_CYCLES = `FSKRX_CLK_HZ / `FSKRX_SAMPLE_HZ;
  localparam logic [15:0] MARK_INC = 16'((64'd`FSKRX_MARK_HZ * 64'd65536 + `FSKRX_SAMPLE_HZ / 2) / `FSKRX_SAMPLE_HZ);
  localparam logic [15:0] SPACE_INC = 16'((64'd`FSKRX_SPACE_HZ * 64'd65536 + `FSKRX_SAMPLE_HZ / 2) / `FSKRX_SAMPLE_HZ);
  localparam logic [5:0] MSG_LEN = 6'(`FSKRX_MESSAGE_BITS);

  // Sum of one word as +1/-1 per bit, range -11..+11
  function automatic logic signed [4:0] word_sum(input logic [`FSKRX_BITS_PER_WORD-1:0] bits);
    logic [3:0] ones;
    ones = 4'h0;
    for (int i = 0; i < `FSKRX_BITS_PER_WORD; i++)
    begin
      ones = ones + 4'(bits[i]);
    end
    word_sum = 5'(signed'({1'b0, ones, 1'b0})) - 5'sd11;
  endfunction : word_sum

  // Magnitude of a correlation accumulator
  function automatic logic [23:0] mag(input logic signed [23:0] v);
    mag = v[23] ? 24'(-v) : 24'(v);
  endfunction : mag

  fskrx_state_type state_r, state_nxt;
  fskrx_class_type class_r;
  logic [6:0] smp_cnt_r;
  logic [31:0] bit_cnt_r;
  logic [31:0] tmo_cnt_r;
  logic [31:0] blink_cnt_r;
  logic bit_tick;
  logic tmo_hit;
  logic [15:0] mark_ph_r, space_ph_r;
  logic signed [23:0] mi_r, mq_r, si_r, sq_r;
  logic [23:0] energy_r;
  logic signed [12:0] scaled;
  logic [24:0] mark_str, space_str, best_str;
  logic [47:0] str_scaled, thr_scaled;
  logic detected, is_mark;
  logic [`FSKRX_MESSAGE_BITS-1:0] buf_r;
  logic [5:0] fill_r;
  logic pkt_flag_r, tmo_flag_r, last_tmo_r;
  logic signed [4:0] w0_r, w1_r, w2_r;
  logic signed [6:0] psum_r;
  logic signed [4:0] w0_c, w1_c, w2_c;
  logic signed [6:0] psum_c;
  logic start_r, auto_r;
  logic [15:0] thresh_r;
  logic wb_hit, wb_wr, clr_pkt, clr_tmo;
  logic pkt_set, tmo_set;

  assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr = wb_hit && WB_WE_I;
  assign clr_pkt = wb_wr && WB_ADR_I == `FSKRX_ADDR_STATUS && WB_SEL_I[0] && WB_DAT_I[`FSKRX_STAT_PKT];
  assign clr_tmo = wb_wr && WB_ADR_I == `FSKRX_ADDR_STATUS && WB_SEL_I[0] && WB_DAT_I[`FSKRX_STAT_TMO];

  // Sampling tick, runs only while receiving
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      smp_cnt_r <= 7'h00;
    else if (CLK_EN)
    begin
      if (state_r != FSKRX_RECV || smp_cnt_r == 7'(SAMPLE_CYCLES - 1))
        smp_cnt_r <= 7'h00;
      else
        smp_cnt_r <= smp_cnt_r + 7'h01;
    end
  end
  assign SAMPLE_TICK = CLK_EN && state_r == FSKRX_RECV && smp_cnt_r == 7'(SAMPLE_CYCLES - 1);

  // Bit-decision tick, three per bit period of the sender
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      bit_cnt_r <= 32'h0;
    else if (CLK_EN)
    begin
      if (state_r != FSKRX_RECV || bit_tick)
        bit_cnt_r <= 32'h0;
      else
        bit_cnt_r <= bit_cnt_r + 32'h1;
    end
  end
  assign bit_tick = CLK_EN && state_r == FSKRX_RECV && bit_cnt_r == 32'(BIT_TICK_CYCLES - 1);

  // Timeout counter, cleared outside reception and on each packet
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      tmo_cnt_r <= 32'h0;
    else if (CLK_EN)
    begin
      if (state_r != FSKRX_RECV || pkt_set)
        tmo_cnt_r <= 32'h0;
      else
        tmo_cnt_r <= tmo_cnt_r + 32'h1;
    end
  end
  assign tmo_hit = CLK_EN && state_r == FSKRX_RECV && !pkt_set && tmo_cnt_r == 32'(TIMEOUT_CYCLES - 1);

  // Scaled sample around mid-scale
  assign scaled = 13'(signed'({1'b0, ADC_DATA})) - 13'sh0800;

  // Tone correlators with square references
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mark_ph_r <= 16'h0000;
      space_ph_r <= 16'h0000;
      mi_r <= 24'sh0;
      mq_r <= 24'sh0;
      si_r <= 24'sh0;
      sq_r <= 24'sh0;
      energy_r <= 24'h0;
    end
    else if (CLK_EN)
    begin
      if (state_r != FSKRX_RECV || bit_tick)
      begin
        mi_r <= 24'sh0;
        mq_r <= 24'sh0;
        si_r <= 24'sh0;
        sq_r <= 24'sh0;
        energy_r <= 24'h0;
      end
      else if (SAMPLE_TICK)
      begin
        mark_ph_r <= mark_ph_r + MARK_INC;
        space_ph_r <= space_ph_r + SPACE_INC;
        mi_r <= (mark_ph_r[15] == mark_ph_r[14]) ? mi_r + 24'(scaled) : mi_r - 24'(scaled);
        mq_r <= !mark_ph_r[15] ? mq_r + 24'(scaled) : mq_r - 24'(scaled);
        si_r <= (space_ph_r[15] == space_ph_r[14]) ? si_r + 24'(scaled) : si_r - 24'(scaled);
        sq_r <= !space_ph_r[15] ? sq_r + 24'(scaled) : sq_r - 24'(scaled);
        energy_r <= energy_r + mag(24'(scaled));
      end
    end
  end

  // Strength comparison against threshold times signal energy
  assign mark_str = 25'(mag(mi_r)) + 25'(mag(mq_r));
  assign space_str = 25'(mag(si_r)) + 25'(mag(sq_r));
  assign is_mark = mark_str >= space_str;
  assign best_str = is_mark ? mark_str : space_str;
  assign str_scaled = {7'h00, best_str, 16'h0000};
  assign thr_scaled = 48'(thresh_r) * 48'(energy_r);
  assign detected = best_str != 25'h0 && str_scaled >= thr_scaled;

  // Received bit buffer, mark stored as 1 (+1) and space as 0 (-1)
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      buf_r <= '0;
      fill_r <= 6'h00;
    end
    else if (CLK_EN)
    begin
      if (state_r == FSKRX_PACK)
      begin
        buf_r <= '0;
        fill_r <= 6'h00;
      end
      else if (bit_tick && detected && fill_r < MSG_LEN)
      begin
        buf_r[fill_r] <= is_mark;
        fill_r <= fill_r + 6'h01;
      end
    end
  end
  assign pkt_set = state_r == FSKRX_RECV && fill_r == MSG_LEN;
  assign tmo_set = tmo_hit;

  // Word and packet sums from the buffer
  assign w0_c = word_sum(buf_r[10:0]);
  assign w1_c = word_sum(buf_r[21:11]);
  assign w2_c = word_sum(buf_r[32:22]);
  assign psum_c = 7'(w0_c) + 7'(w1_c) + 7'(w2_c);

  // Sequence of reception, packetizing and indication
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      FSKRX_IDLE:
        if (start_r)
          state_nxt = FSKRX_RECV;
      FSKRX_RECV:
        if (pkt_set || tmo_set)
          state_nxt = FSKRX_PACK;
      FSKRX_PACK:
        state_nxt = FSKRX_SHOW;
      FSKRX_SHOW:
        if (blink_cnt_r == 32'(BLINK_CYCLES - 1))
          state_nxt = auto_r ? FSKRX_RECV : FSKRX_IDLE;
      default:
        state_nxt = FSKRX_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      state_r <= FSKRX_IDLE;
    else if (CLK_EN)
      state_r <= state_nxt;
  end

  // Indication time counter
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      blink_cnt_r <= 32'h0;
    else if (CLK_EN)
      blink_cnt_r <= (state_r == FSKRX_SHOW) ? blink_cnt_r + 32'h1 : 32'h0;
  end

  // Packet results and classification
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      w0_r <= 5'sh0;
      w1_r <= 5'sh0;
      w2_r <= 5'sh0;
      psum_r <= 7'sh0;
      class_r <= FSKRX_RES_NONE;
      last_tmo_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (state_r == FSKRX_RECV && tmo_set)
        last_tmo_r <= 1'b1;
      else if (state_r == FSKRX_RECV && pkt_set)
        last_tmo_r <= 1'b0;
      if (state_r == FSKRX_PACK)
      begin
        w0_r <= w0_c;
        w1_r <= w1_c;
        w2_r <= w2_c;
        psum_r <= psum_c;
        if (last_tmo_r)
          class_r <= FSKRX_RES_OTHER;
        else if (psum_c == 7'sd3)
          class_r <= FSKRX_RES_ONE;
        else if (psum_c == -7'sd3)
          class_r <= FSKRX_RES_ZERO;
        else
          class_r <= FSKRX_RES_OTHER;
      end
    end
  end

  // Indicator drive while showing the result
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      LED_BLUE <= 1'b0;
      LED_RED <= 1'b0;
    end
    else if (CLK_EN)
    begin
      LED_BLUE <= state_nxt == FSKRX_SHOW && state_r != FSKRX_PACK ? class_r[0] : 1'b0;
      LED_RED <= state_nxt == FSKRX_SHOW && state_r != FSKRX_PACK ? class_r[1] : 1'b0;
    end
  end

  // Sticky packet and timeout flags, set wins over clear
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pkt_flag_r <= 1'b0;
      tmo_flag_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (pkt_set)
        pkt_flag_r <= 1'b1;
      else if (clr_pkt)
        pkt_flag_r <= 1'b0;
      if (tmo_set)
        tmo_flag_r <= 1'b1;
      else if (clr_tmo)
        tmo_flag_r <= 1'b0;
    end
  end
  assign PACKET_FLAG = pkt_flag_r;

  // Control and threshold registers
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      start_r <= 1'b0;
      auto_r <= 1'b0;
      thresh_r <= `FSKRX_THRESH_RESET;
    end
    else if (CLK_EN)
    begin
      start_r <= 1'b0;
      if (wb_wr && WB_ADR_I == `FSKRX_ADDR_CTRL && WB_SEL_I[0])
      begin
        start_r <= WB_DAT_I[`FSKRX_CTRL_START];
        auto_r <= WB_DAT_I[`FSKRX_CTRL_AUTO];
      end
      else if (wb_wr && WB_ADR_I == `FSKRX_ADDR_THRESH)
      begin
        if (WB_SEL_I[0])
          thresh_r[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1])
          thresh_r[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  // Bus answer one cycle after the request, read data registered
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end
    else if (CLK_EN)
    begin
      WB_ACK_O <= wb_hit;
      WB_DAT_O <= 32'h0;
      if (wb_hit && !WB_WE_I)
      begin
        if (WB_ADR_I == `FSKRX_ADDR_CTRL)
          WB_DAT_O <= {30'h0, auto_r, 1'b0};
        else if (WB_ADR_I == `FSKRX_ADDR_THRESH)
          WB_DAT_O <= {16'h0, thresh_r};
        else if (WB_ADR_I == `FSKRX_ADDR_STATUS)
          WB_DAT_O <= {20'h0, fill_r, class_r, tmo_flag_r, pkt_flag_r, state_r};
        else if (WB_ADR_I == `FSKRX_ADDR_RESULT)
          WB_DAT_O <= {1'b0, psum_r, 3'h0, w2_r, 3'h0, w1_r, 3'h0, w0_r};
        else if (WB_ADR_I == `FSKRX_ADDR_BITS_LO)
          WB_DAT_O <= buf_r[31:0];
        else if (WB_ADR_I == `FSKRX_ADDR_BITS_HI)
          WB_DAT_O <= {31'h0, buf_r[32]};
      end
    end
  end

endmodule : fskrx_top

// [verilog/fskrx_params.svh]
`ifndef FSKRX_PARAMS_SVH
`define FSKRX_PARAMS_SVH

// System clock and rates
`define FSKRX_CLK_HZ 25000000
`define FSKRX_SAMPLE_HZ 300000
`define FSKRX_BIT_DECISION_MHZ 585920
`define FSKRX_BIT_DECISION_NOM_MHZ 585938
`define FSKRX_TIMEOUT_S 3
`define FSKRX_BLINK_MS 250

// Tone frequencies and phase accumulator width
`define FSKRX_MARK_HZ 131250
`define FSKRX_SPACE_HZ 143750
`define FSKRX_PHASE_BITS 16

// Packet format
`define FSKRX_BITS_PER_WORD 11
`define FSKRX_WORDS_PER_PACKET 3
`define FSKRX_MESSAGE_BITS 33

// Threshold as unsigned fraction of 2^16, 0.1 by default
`define FSKRX_THRESH_FRAC_BITS 16
`define FSKRX_THRESH_RESET 16'h199A

// Register byte offsets
`define FSKRX_ADDR_CTRL 8'h00
`define FSKRX_ADDR_THRESH 8'h04
`define FSKRX_ADDR_STATUS 8'h08
`define FSKRX_ADDR_RESULT 8'h0C
`define FSKRX_ADDR_BITS_LO 8'h10
`define FSKRX_ADDR_BITS_HI 8'h14

// Control and status field positions
`define FSKRX_CTRL_START 0
`define FSKRX_CTRL_AUTO 1
`define FSKRX_STAT_PKT 2
`define FSKRX_STAT_TMO 3

`endif

// [verilog/fskrx_pkg.sv]
package fskrx_pkg;

  // Receiver sequence, Gray coded along idle-receive-packetize-indicate
  typedef enum logic [1:0] {
    FSKRX_IDLE = 2'b00,
    FSKRX_RECV = 2'b01,
    FSKRX_PACK = 2'b11,
    FSKRX_SHOW = 2'b10
  } fskrx_state_type;

  // Outcome of the last packetizing step
  typedef enum logic [1:0] {
    FSKRX_RES_NONE = 2'b00,
    FSKRX_RES_ONE = 2'b01,
    FSKRX_RES_ZERO = 2'b10,
    FSKRX_RES_OTHER = 2'b11
  } fskrx_class_type;

endpackage : fskrx_pkg

// [bench/fskrx_top_props.sv]
`timescale 1ns/100ps
module fskrx_top_props
  import fskrx_pkg::*;
#(
  parameter int BLINK_CYCLES = 50
)
(
  // Clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  // Bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  // Receive side
  input wire logic SAMPLE_TICK,
  input wire logic LED_BLUE,
  input wire logic LED_RED,
  input wire logic PACKET_FLAG
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  logic [9:0] gap_r;
  logic [15:0] led_cnt_r;
  logic led_on;
  logic clr_req;
  // Indication and flag clear request
  assign led_on = LED_BLUE || LED_RED;
  assign clr_req = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == 8'h08 && WB_SEL_I[0] && WB_DAT_I[2];
  // Cycles since last tick, saturating
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      gap_r <= 10'h3FF;
    else if (SAMPLE_TICK)
      gap_r <= 10'h000;
    else if (gap_r != 10'h3FF)
      gap_r <= gap_r + 10'h001;
  end
  // Length of the running indication
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      led_cnt_r <= 16'h0000;
    else if (led_on)
      led_cnt_r <= led_cnt_r + 16'h0001;
    else
      led_cnt_r <= 16'h0000;
  end
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN;
  endsequence
  sequence s_show;
    ##[1:4] led_on;
  endsequence
  a_ack_on_request: assert property (s_req |=> WB_ACK_O)
    else $error("request not acknowledged");
  a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_tick_single: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
    else $error("sample tick longer than one cycle");
  a_tick_spacing: assert property (SAMPLE_TICK |-> gap_r == 10'd82 || gap_r >= 10'd120)
    else $error("sample tick spacing wrong");
  a_show_no_tick: assert property (led_on |-> !SAMPLE_TICK)
    else $error("sampling during indication");
  a_flag_to_show: assert property ($rose(PACKET_FLAG) |-> s_show)
    else $error("packet not indicated");
  a_flag_sticky: assert property ($fell(PACKET_FLAG) |-> $past(clr_req) || $past(clr_req, 2))
    else $error("packet flag dropped by itself");
  a_led_length: assert property ($fell(led_on) |-> led_cnt_r == 16'(BLINK_CYCLES - 1))
    else $error("indication length wrong");
  a_led_colour: assert property (led_on && $past(led_on) |-> $stable({LED_BLUE, LED_RED}))
    else $error("indication colour changed");
endmodule : fskrx_top_props

// [bench/fskrx_tx_model.sv]
`timescale 1ns/100ps
module fskrx_tx_model
  import fskrx_pkg::*;
#(
  parameter int HOLD_CYCLES = 3000
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Symbol request
  input wire logic tone_on,
  input wire logic mark_sel,
  // Converter output
  output logic [11:0] adc_data
);
  logic [31:0] phase_r;
  logic [15:0] hold_r;
  logic mark_r;
  // Symbol changes only at bit boundaries
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_r <= 16'h0000;
      mark_r <= 1'b1;
    end
    else if (hold_r == 16'(HOLD_CYCLES - 1))
    begin
      hold_r <= 16'h0000;
      mark_r <= mark_sel;
    end
    else
      hold_r <= hold_r + 16'h0001;
  end
  // Tone phase at mark or space rate
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_r <= 32'h00000000;
    else
      phase_r <= phase_r + (mark_r ? 32'h01581062 : 32'h0178D4FD);
  end
  // Square tone, mid-scale when quiet
  assign adc_data = tone_on ? (phase_r[31] ? 12'hC00 : 12'h400) : 12'h800;
endmodule : fskrx_tx_model

// [bench/tb.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("wrong value at %0t: compare failed", $time); end end
module tb
  import fskrx_pkg::*;
;
  localparam int BT = 1000;
  localparam int TO = 40000;
  logic clk, rstn, cyc, stb, we, ack, tick, blue, red, flag, tone_on, mark_sel;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, rd;
  logic [11:0] adc;
  int cycles, t0, n, bad_count, total_checks;
  fskrx_top #(.BIT_TICK_CYCLES(BT), .TIMEOUT_CYCLES(TO), .BLINK_CYCLES(50)) u_fskrx_top (
    .SYS_CLK(clk), .RSTN(rstn), .CLK_EN(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .ADC_DATA(adc), .SAMPLE_TICK(tick), .LED_BLUE(blue), .LED_RED(red), .PACKET_FLAG(flag));
  fskrx_tx_model #(.HOLD_CYCLES(3 * BT)) u_fskrx_tx_model (
    .clk(clk), .rst_n(rstn), .tone_on(tone_on), .mark_sel(mark_sel), .adc_data(adc));
  // Verdict and end of run
  task conclude;
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // One classic bus cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk
  task automatic wait_led(input logic lvl);
    while ((blue === 1'b1 || red === 1'b1) !== lvl) @(posedge clk);
  endtask : wait_led
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Cycle count and hang limit
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 95000)
    begin
      bad_count++;
      conclude();
    end
  end
  // Main sequence
  initial
  begin
    {rstn, cyc, stb, we, adr, dat_i, cycles, bad_count, total_checks} = '0;
    {sel, tone_on, mark_sel} = {4'hF, 2'b11};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rdchk(8'h04, 32'h0000199A);
    rdchk(8'h08, 32'h0);
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    rdchk(8'h20, 32'h0);
    wb(1'b1, 8'h00, 32'h1);
    t0 = cycles;
    rdchk(8'h08, 32'h1);
    while (flag !== 1'b1) @(posedge clk);
    `CHK((cycles - t0) / BT, 33)
    wait_led(1'b1);
    `CHK({blue, red}, 2'b11)
    wait_led(1'b0);
    rdchk(8'h0C, 32'h210B0B0B);
    rdchk(8'h08, 32'h34);
    rdchk(8'h10, 32'h0);
    rdchk(8'h14, 32'h0);
    wb(1'b1, 8'h08, 32'h4);
    @(posedge clk);
    `CHK(flag, 1'b0)
    wb(1'b1, 8'h04, 32'hFFFF);
    rdchk(8'h04, 32'hFFFF);
    mark_sel <= 1'b0;
    tone_on <= 1'b0;
    n = 0;
    repeat (200) @(posedge clk) n += tick;
    `CHK(n, 0)
    wb(1'b1, 8'h00, 32'h1);
    t0 = cycles;
    wait_led(1'b1);
    `CHK((cycles - t0) / TO, 1)
    `CHK({blue, red, flag}, 3'b110)
    wait_led(1'b0);
    rdchk(8'h08, 32'h38);
    conclude();
  end
endmodule : tb
bind fskrx_top fskrx_top_props #(.BLINK_CYCLES(BLINK_CYCLES)) u_fskrx_top_props (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CLK_EN(CLK_EN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_ACK_O(WB_ACK_O), .SAMPLE_TICK(SAMPLE_TICK), .LED_BLUE(LED_BLUE), .LED_RED(LED_RED),
  .PACKET_FLAG(PACKET_FLAG));
